/* core/burst_sram_map.svh */
`ifndef BURST_SRAM_MAP_SVH
`define BURST_SRAM_MAP_SVH

// Word width (widest configuration) and address width
`define WORD_W            36
`define ADDR_W            20
// Words per address, always two
`define BURST_LEN         2
// Read data buffer
`define FIFO_DEPTH        16
`define FIFO_AW           4
// Free entries kept in reserve before refusing reads
`define READY_MARGIN      2
// Read latency in output half cycles
`define LAT_HALF_LOOP_ON  3
`define LAT_HALF_LOOP_OFF 2

`endif

/* core/burst_sram_pkg.sv */
`include "burst_sram_map.svh"

package burst_sram_pkg;
  typedef logic [`WORD_W-1:0]           word_t;
  typedef logic [`ADDR_W-1:0]           addr_t;
  typedef logic [`BURST_LEN*`WORD_W-1:0] burst_t;
  typedef enum logic [1:0] {
    OUT_IDLE,
    OUT_WAIT,
    OUT_WORD0,
    OUT_WORD1
  } out_state_e;
endpackage

/* core/burst_sram_port.sv */
`timescale 1ns/1ps

module async_burst_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Fill side
  input  wire logic             wr_clk_i,
  input  wire logic             wr_rst_n_i,
  input  wire logic             wr_valid_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  output logic                  wr_ready_o,
  output logic [AW:0]           wr_level_o,
  // Drain side
  input  wire logic             rd_clk_i,
  input  wire logic             rd_rst_n_i,
  output logic                  rd_valid_o,
  output logic [WIDTH-1:0]      rd_data_o,
  input  wire logic             rd_ready_i
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_bin_r;
  logic [AW:0]      wr_gray_r;
  logic [AW:0]      rd_bin_r;
  logic [AW:0]      rd_gray_r;
  logic [AW:0]      rd_gray_s1_r;
  logic [AW:0]      rd_gray_s2_r;
  logic [AW:0]      wr_gray_s1_r;
  logic [AW:0]      wr_gray_s2_r;
  logic [AW:0]      wr_bin_nxt;
  logic [AW:0]      rd_bin_nxt;
  logic [AW:0]      rd_bin_seen;
  logic             full;
  logic             empty;

  function automatic logic [AW:0] gray_to_bin(input logic [AW:0] g);
    logic [AW:0] b;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  assign full        = wr_gray_r == {~rd_gray_s2_r[AW:AW-1], rd_gray_s2_r[AW-2:0]};
  assign empty       = rd_gray_r == wr_gray_s2_r;
  assign wr_ready_o  = !full;
  assign rd_valid_o  = !empty;
  assign rd_data_o   = mem[rd_bin_r[AW-1:0]];
  assign wr_bin_nxt  = wr_bin_r + {{AW{1'b0}}, (wr_valid_i && !full)};
  assign rd_bin_nxt  = rd_bin_r + {{AW{1'b0}}, (rd_ready_i && !empty)};
  assign rd_bin_seen = gray_to_bin(rd_gray_s2_r);
  assign wr_level_o  = wr_bin_r - rd_bin_seen;

  always_ff @(posedge wr_clk_i) begin
    if (wr_valid_i && !full) begin
      mem[wr_bin_r[AW-1:0]] <= wr_data_i;
    end
  end

  always_ff @(posedge wr_clk_i or negedge wr_rst_n_i) begin
    if (!wr_rst_n_i) begin
      wr_bin_r     <= '0;
      wr_gray_r    <= '0;
      rd_gray_s1_r <= '0;
      rd_gray_s2_r <= '0;
    end else begin
      wr_bin_r     <= wr_bin_nxt;
      wr_gray_r    <= wr_bin_nxt ^ (wr_bin_nxt >> 1);
      rd_gray_s1_r <= rd_gray_r;
      rd_gray_s2_r <= rd_gray_s1_r;
    end
  end

  always_ff @(posedge rd_clk_i or negedge rd_rst_n_i) begin
    if (!rd_rst_n_i) begin
      rd_bin_r     <= '0;
      rd_gray_r    <= '0;
      wr_gray_s1_r <= '0;
      wr_gray_s2_r <= '0;
    end else begin
      rd_bin_r     <= rd_bin_nxt;
      rd_gray_r    <= rd_bin_nxt ^ (rd_bin_nxt >> 1);
      wr_gray_s1_r <= wr_gray_r;
      wr_gray_s2_r <= wr_gray_s1_r;
    end
  end
endmodule

module burst_sram_port
  import burst_sram_pkg::*;
(
  // Input clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Output clock from the controller
  input  wire logic        out_clk_i,
  // Command, write data, input phase and read ready
  input  wire logic        rd_sel_n_i,
  input  wire logic        wr_sel_n_i,
  input  wire logic [`ADDR_W-1:0] addr_i,
  input  wire logic [`WORD_W-1:0] wr_data_i,
  output logic             k_phase_o,
  output logic             rd_ready_o,
  // Mode pin
  input  wire logic        phase_loop_disable_i,
  // Read data and echo strobes
  output logic [`WORD_W-1:0] q_data_o,
  output logic             q_valid_o,
  output logic             echo_strobe_output_o,
  output logic             echo_strobe_output_n_o
);
  localparam logic [`FIFO_AW:0] READY_LIMIT = (`FIFO_AW+1)'(`FIFO_DEPTH - `READY_MARGIN);
  localparam logic [1:0]        LAT_ON      = 2'(`LAT_HALF_LOOP_ON);
  localparam logic [1:0]        LAT_OFF     = 2'(`LAT_HALF_LOOP_OFF);

  logic       rst_s1_r;
  logic       rst_sync_r;
  logic       c_rst_s1_r;
  logic       c_rst_sync_r;
  // Input side
  logic       k_phase_r;
  logic       rd_req_r;
  addr_t      rd_addr_r;
  logic       wr_req_r;
  word_t      wr_w0_r;
  logic       wr_pend_r;
  addr_t      wr_addr_r;
  burst_t     wr_burst_r;
  word_t      mem [2**`ADDR_W][`BURST_LEN];
  burst_t     rd_burst;
  logic       push;
  logic       fifo_wr_ready;
  logic [`FIFO_AW:0] fifo_level;
  // Output side
  logic       loop_s1_r;
  logic       loop_s2_r;
  logic       loop_s3_r;
  logic       loop_on_r;
  logic       c_phase_r;
  out_state_e out_state_r;
  logic [1:0] lat_cnt_r;
  logic       fifo_rd_valid;
  burst_t     fifo_rd_data;
  logic       pop;
  logic       launch;
  logic       lat_done;

  // Reset release, input domain
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r   <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_s1_r   <= 1'b1;
      rst_sync_r <= rst_s1_r;
    end
  end

  // Reset release, output domain
  always_ff @(posedge out_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c_rst_s1_r   <= 1'b0;
      c_rst_sync_r <= 1'b0;
    end else begin
      c_rst_s1_r   <= 1'b1;
      c_rst_sync_r <= c_rst_s1_r;
    end
  end

  // Input edge phase: 0 is the clock rise, 1 the complement rise
  always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      k_phase_r <= 1'b0;
      k_phase_o <= 1'b0;
    end else begin
      k_phase_r <= ~k_phase_r;
      k_phase_o <= ~k_phase_r;
    end
  end

  // Input registers: read address and first write word on the rise
  always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rd_req_r  <= 1'b0;
      rd_addr_r <= '0;
      wr_req_r  <= 1'b0;
      wr_w0_r   <= '0;
    end else if (!k_phase_r) begin
      rd_req_r  <= !rd_sel_n_i && rd_ready_o;
      rd_addr_r <= addr_i;
      wr_req_r  <= !wr_sel_n_i;
      wr_w0_r   <= wr_data_i;
    end
  end

  // Write address and second word on the complement rise
  always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      wr_pend_r  <= 1'b0;
      wr_addr_r  <= '0;
      wr_burst_r <= '0;
    end else if (k_phase_r) begin
      wr_pend_r  <= wr_req_r;
      wr_addr_r  <= addr_i;
      wr_burst_r <= {wr_data_i, wr_w0_r};
    end else begin
      wr_pend_r  <= 1'b0;
    end
  end

  // Self-timed array write on the following rise
  always_ff @(posedge ref_clk_i) begin
    if (wr_pend_r) begin
      mem[wr_addr_r][0] <= wr_burst_r[`WORD_W-1:0];
      mem[wr_addr_r][1] <= wr_burst_r[2*`WORD_W-1:`WORD_W];
    end
  end

  // Read lookup with forwarding of a write in flight
  always_comb begin
    rd_burst = {mem[rd_addr_r][1], mem[rd_addr_r][0]};
    if (wr_pend_r && wr_addr_r == rd_addr_r) begin
      rd_burst = wr_burst_r;
    end
    if (wr_req_r && addr_i == rd_addr_r) begin
      rd_burst = {wr_data_i, wr_w0_r};
    end
  end

  assign push = k_phase_r && rd_req_r;

  always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rd_ready_o <= 1'b0;
    end else begin
      rd_ready_o <= fifo_wr_ready && (fifo_level < READY_LIMIT);
    end
  end

  async_burst_fifo #(
    .WIDTH (`BURST_LEN*`WORD_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_rd_fifo (
    .wr_clk_i   (ref_clk_i),
    .wr_rst_n_i (rst_sync_r),
    .wr_valid_i (push),
    .wr_data_i  (rd_burst),
    .wr_ready_o (fifo_wr_ready),
    .wr_level_o (fifo_level),
    .rd_clk_i   (out_clk_i),
    .rd_rst_n_i (c_rst_sync_r),
    .rd_valid_o (fifo_rd_valid),
    .rd_data_o  (fifo_rd_data),
    .rd_ready_i (pop)
  );

  // Loop-disable pin, three stages, change taken when stages two and three agree
  always_ff @(posedge out_clk_i or negedge c_rst_sync_r) begin
    if (!c_rst_sync_r) begin
      loop_s1_r <= 1'b0;
      loop_s2_r <= 1'b0;
      loop_s3_r <= 1'b0;
      loop_on_r <= 1'b0;
    end else begin
      loop_s1_r <= phase_loop_disable_i;
      loop_s2_r <= loop_s1_r;
      loop_s3_r <= loop_s2_r;
      if (loop_s2_r == loop_s3_r) begin
        loop_on_r <= loop_s3_r;
      end
    end
  end

  // Output edge phase and echo strobes
  always_ff @(posedge out_clk_i or negedge c_rst_sync_r) begin
    if (!c_rst_sync_r) begin
      c_phase_r              <= 1'b1;
      echo_strobe_output_o   <= 1'b0;
      echo_strobe_output_n_o <= 1'b0;
    end else begin
      c_phase_r              <= ~c_phase_r;
      echo_strobe_output_o   <= c_phase_r;
      echo_strobe_output_n_o <= ~c_phase_r;
    end
  end

  // The count starts on an output clock rise, so word0 keeps a fixed
  // phase per mode and the two latencies stay half a cycle apart
  assign launch   = fifo_rd_valid && c_phase_r;
  assign lat_done = lat_cnt_r == 2'd0;
  assign pop      = out_state_r == OUT_WORD0;

  // Output sequencer state
  always_ff @(posedge out_clk_i or negedge c_rst_sync_r) begin
    if (!c_rst_sync_r) begin
      out_state_r <= OUT_IDLE;
    end else begin
      unique case (out_state_r)
        OUT_IDLE: begin
          if (launch) begin
            out_state_r <= OUT_WAIT;
          end
        end
        OUT_WAIT: begin
          if (lat_done) begin
            out_state_r <= OUT_WORD0;
          end
        end
        OUT_WORD0: begin
          out_state_r <= OUT_WORD1;
        end
        OUT_WORD1: begin
          if (fifo_rd_valid) begin
            out_state_r <= OUT_WORD0;
          end else begin
            out_state_r <= OUT_IDLE;
          end
        end
      endcase
    end
  end

  // Latency count, loaded as a burst is seen from idle
  always_ff @(posedge out_clk_i or negedge c_rst_sync_r) begin
    if (!c_rst_sync_r) begin
      lat_cnt_r <= '0;
    end else if (out_state_r == OUT_IDLE && launch) begin
      lat_cnt_r <= (loop_on_r ? LAT_ON : LAT_OFF) - 2'd1;
    end else if (out_state_r == OUT_WAIT && !lat_done) begin
      lat_cnt_r <= lat_cnt_r - 2'd1;
    end
  end

  // Output data registers on the output clock pair
  always_ff @(posedge out_clk_i or negedge c_rst_sync_r) begin
    if (!c_rst_sync_r) begin
      q_data_o  <= '0;
      q_valid_o <= 1'b0;
    end else begin
      unique case (out_state_r)
        OUT_IDLE: begin
          q_valid_o <= 1'b0;
        end
        OUT_WAIT: begin
          if (lat_done) begin
            q_data_o  <= fifo_rd_data[`WORD_W-1:0];
            q_valid_o <= 1'b1;
          end
        end
        OUT_WORD0: begin
          q_data_o  <= fifo_rd_data[2*`WORD_W-1:`WORD_W];
          q_valid_o <= 1'b1;
        end
        OUT_WORD1: begin
          q_data_o  <= fifo_rd_data[`WORD_W-1:0];
          q_valid_o <= fifo_rd_valid;
        end
      endcase
    end
  end
endmodule

/* tb/burst_sram_properties.sv */
`timescale 1ns/1ps
module burst_sram_properties
  import burst_sram_pkg::*;
(
  // Clocks and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic out_clk_i,
  // Watched outputs
  input wire logic k_phase_o,
  input wire logic q_valid_o,
  input wire logic echo_strobe_output_o,
  input wire logic echo_strobe_output_n_o,
  // Mode pin
  input wire logic phase_loop_disable_i
);
  logic par_r;
  logic eo;
  logic en;
  assign eo = echo_strobe_output_o;
  assign en = echo_strobe_output_n_o;
  // Odd while a burst is half sent
  always_ff @(posedge out_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) par_r <= 1'b0;
    else if (q_valid_o) par_r <= ~par_r;
  end
  echo_pair_a: assert property (@(posedge out_clk_i) disable iff (!rst_n_i)
    q_valid_o |-> eo != en) else $error("echo pair not complementary");
  echo_hold_a: assert property (@(posedge out_clk_i) disable iff (!rst_n_i)
    (eo ^ en) |=> (eo ^ en)) else $error("echo pair lost complement");
  echo_toggle_a: assert property (@(posedge out_clk_i) disable iff (!rst_n_i)
    (eo ^ en) |=> eo != $past(eo)) else $error("echo strobe missed a toggle");
  burst_two_a: assert property (@(posedge out_clk_i) disable iff (!rst_n_i)
    $rose(q_valid_o) |=> q_valid_o) else $error("single word burst");
  burst_even_a: assert property (@(posedge out_clk_i) disable iff (!rst_n_i)
    $fell(q_valid_o) |-> !par_r) else $error("odd word count in burst");
  // Word0 on the complement rise with the loop disabled, on the clock rise with it on
  burst_align_a: assert property (@(posedge out_clk_i) disable iff (!rst_n_i)
    q_valid_o && !par_r |-> eo == !phase_loop_disable_i) else $error("word0 off phase");
  phase_fall_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    k_phase_o |=> !k_phase_o) else $error("input slot repeated");
  phase_rise_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(k_phase_o) |=> k_phase_o) else $error("input slot stalled");
endmodule

bind burst_sram_port burst_sram_properties u_burst_sram_properties (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .out_clk_i(out_clk_i), .k_phase_o(k_phase_o),
  .q_valid_o(q_valid_o), .echo_strobe_output_o(echo_strobe_output_o),
  .echo_strobe_output_n_o(echo_strobe_output_n_o),
  .phase_loop_disable_i(phase_loop_disable_i));

/* tb/sram_ctrl_model.sv */
`timescale 1ns/1ps
module sram_ctrl_model
  import burst_sram_pkg::*;
(
  // Clock source
  input  wire logic               ref_clk_i,
  input  wire logic               single_i,
  output logic                    out_clk_o,
  // Read capture
  input  wire logic               q_valid_i,
  input  wire logic [`WORD_W-1:0] q_data_i
);
  logic  link_clk = 1'b0;
  word_t words[$];
  always #16 link_clk = ~link_clk;
  // Separate output clock, or the input clock in single mode
  assign out_clk_o = single_i ? ref_clk_i : link_clk;
  // Rising edges only
  always @(posedge out_clk_o) if (q_valid_i) words.push_back(q_data_i);
endmodule

/* tb/burst_sram_port_tb.sv */
`timescale 1ns/1ps
module burst_sram_port_tb;
  import burst_sram_pkg::*;
  logic  clk = 1'b0;
  logic  rst_n = 1'b0;
  logic  single = 1'b0;
  logic  oclk;
  logic  rs_n = 1'b1;
  logic  ws_n = 1'b1;
  addr_t addr = '0;
  word_t wd = '0;
  logic  ld = 1'b1;
  logic  kph;
  logic  rdy;
  logic  qv;
  logic  eo;
  logic  en;
  word_t qd;
  int    n_errors = 0;
  int    checked = 0;
  int    cycles = 0;
  always #2.5 clk = ~clk;
  burst_sram_port u_burst_sram_port (.ref_clk_i(clk), .rst_n_i(rst_n), .out_clk_i(oclk),
    .rd_sel_n_i(rs_n), .wr_sel_n_i(ws_n), .addr_i(addr), .wr_data_i(wd), .k_phase_o(kph),
    .rd_ready_o(rdy), .phase_loop_disable_i(ld), .q_data_o(qd), .q_valid_o(qv),
    .echo_strobe_output_o(eo), .echo_strobe_output_n_o(en));
  sram_ctrl_model u_sram_ctrl_model (.ref_clk_i(clk), .single_i(single), .out_clk_o(oclk),
    .q_valid_i(qv), .q_data_i(qd));
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      summarize();
    end
  end
  task automatic chk(input string nm, input word_t seen, input word_t exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic word_t got(input int i);
    return u_sram_ctrl_model.words[i];
  endfunction
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk("q_valid_o", word_t'(qv), '0);
    chk("echo pair", word_t'({eo, en}), '0);
    rst_n <= 1'b1;
    for (int i = 0; i < 50 && rdy !== 1'b1; i++) @(posedge clk);
    // Let the output side leave reset and the mode pin settle
    repeat (60) @(posedge clk);
    u_sram_ctrl_model.words.delete();
  endtask
  task automatic xfer(input logic rd, input addr_t ra, input logic wr, input addr_t wa,
                      input word_t w0, input word_t w1, output logic took);
    // Phase high before an edge makes the following edge a read slot
    do @(posedge clk); while (kph !== 1'b1);
    rs_n <= ~rd;
    ws_n <= ~wr;
    addr <= ra;
    wd   <= w0;
    @(posedge clk);
    took = rdy;
    rs_n <= 1'b1;
    ws_n <= 1'b1;
    addr <= wa;
    wd   <= w1;
  endtask
  task automatic wait_words(input int n);
    for (int i = 0; i < 3000 && u_sram_ctrl_model.words.size() < n; i++) @(posedge clk);
  endtask
  task automatic t_write_read();
    logic t;
    xfer(1'b0, '0, 1'b1, 20'h00005, 36'hA5A5A5A51, 36'h5A5A5A5A2, t);
    xfer(1'b1, 20'h00005, 1'b0, '0, '0, '0, t);
    wait_words(2);
    chk("word0", got(0), 36'hA5A5A5A51);
    chk("word1", got(1), 36'h5A5A5A5A2);
    $display("test write_read done");
  endtask
  task automatic t_coherent();
    logic t;
    xfer(1'b0, '0, 1'b1, 20'h00009, 36'h111111111, 36'h222222222, t);
    xfer(1'b1, 20'h00009, 1'b1, 20'h00009, 36'h333333333, 36'h444444444, t);
    wait_words(4);
    chk("fwd word0", got(2), 36'h333333333);
    chk("fwd word1", got(3), 36'h444444444);
    $display("test coherent done");
  endtask
  task automatic t_select();
    logic t;
    u_sram_ctrl_model.words.delete();
    xfer(1'b0, 20'h00005, 1'b0, 20'h00005, 36'hFFFFFFFFF, 36'hFFFFFFFFF, t);
    xfer(1'b1, 20'h00005, 1'b0, '0, '0, '0, t);
    repeat (200) @(posedge clk);
    chk("burst count", word_t'(u_sram_ctrl_model.words.size()), 36'h2);
    chk("kept word0", got(0), 36'hA5A5A5A51);
    $display("test select done");
  endtask
  task automatic t_fill();
    logic t;
    int   acc;
    acc = 0;
    u_sram_ctrl_model.words.delete();
    for (int i = 0; i < 20; i++) begin
      xfer(1'b1, 20'h00005, 1'b0, '0, '0, '0, t);
      acc += (t === 1'b1);
    end
    chk("refused", word_t'(acc < 20), 36'h1);
    wait_words(2 * acc);
    repeat (200) @(posedge clk);
    chk("drained", word_t'(u_sram_ctrl_model.words.size()), word_t'(2 * acc));
    for (int i = 0; i < 2 * acc; i++)
      chk("fill word", got(i), i[0] ? 36'h5A5A5A5A2 : 36'hA5A5A5A51);
    $display("test fill done");
  endtask
  task automatic t_latency();
    int   lat[2];
    logic t;
    single <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      ld <= m[0];
      do_reset();
      repeat (10) @(posedge clk);
      xfer(1'b1, 20'h00005, 1'b0, '0, '0, '0, t);
      lat[m] = 0;
      while (qv !== 1'b1 && lat[m] < 40) begin
        @(posedge clk);
        lat[m]++;
      end
    end
    chk("latency step", word_t'(lat[1] - lat[0]), 36'h1);
    $display("test latency done");
  endtask
  initial begin
    do_reset();
    t_write_read();
    t_coherent();
    t_select();
    t_fill();
    t_latency();
    summarize();
  end
endmodule
